/* common/fb_frame_pkg.sv */
package fb_frame_pkg;

  // Fieldbus data area limit, bytes per direction
  localparam int MAX_LEN = 500;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BLOCK = 8'h04;
  localparam logic [7:0] REG_TIMEOUT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_COUNTS = 8'h10;

  // Field positions
  localparam int BLOCK_IN_LSB = 0;
  localparam int BLOCK_OUT_LSB = 16;
  localparam int STAT_OVF = 0;
  localparam int STAT_LINK = 1;
  localparam int STAT_RX_BUSY = 2;
  localparam int STAT_TX_BUSY = 3;
  localparam int STAT_TRIG_LSB = 8;
  localparam int STAT_LAST_LSB = 16;
  localparam int COUNTS_TX_LSB = 16;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [8:0] BLOCK_LEN_RST = 9'h1f4;

  // Idle pause ending a frame
  localparam int CLK_PERIOD_NS = 5;
  localparam int IDLE_TIMEOUT_NS = 100000;
  localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_NS / CLK_PERIOD_NS;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {END_NONE, END_CHAR, END_TIMEOUT} end_mode_t;

  // Control register image, bit 0 first from the bottom
  typedef struct packed {
    logic [7:0] end_char;
    logic [7:0] start_char;
    logic pad;
    logic cnt_en;
    logic trig_en;
    end_mode_t end_mode;
    logic len_tmo;
    logic len_en;
    logic start_en;
  } cfg_t;

  typedef enum logic [1:0] {R_IDLE, R_LEN, R_DATA, R_COPY} rx_state_t;
  typedef enum logic [2:0] {T_IDLE, T_START, T_LEN, T_DATA, T_END} tx_state_t;

  // Bytes taken by change counter and count prefix in a data area
  function automatic logic [1:0] hdr_len(input cfg_t c);
    return {1'b0, c.trig_en} + {1'b0, c.cnt_en};
  endfunction

endpackage

/* hdl/fb_frame_adapter.sv */
`timescale 1ns/1ps
// Overview of operation
// (R1) With start marker, ignore input until marker
// (R2) With start marker, transmissions begin with it
// (R3) Length field gives exact useful byte count
// (R4) Outgoing length field holds sent byte count
// (R5) No length field: end on end criterion
// (R6) No criteria: read until buffer full
// (R7) Length-with-timeout: discard frame on timeout
// (R8) End marker: collect up to it, end
// (R9) Idle timeout: end frame on pause
// (R10) Idle timeout mode ignores length field
// (R11) End marker appended to every transmission
// (R12) Copy data unchanged, add framing, no ack
// (R13) Change counter: send only on change
// (R14) Count prefix limits forwarded fieldbus bytes
// (R15) Oversized frame: drop excess, flag overflow
// (R16) Short frame: pad area with zero
// (R17) Count prefix toward master holds rx count
// (R18) Change counter incremented per received frame
// (R19) Data areas up to 500 bytes, variable
// (R20) No exchange before startup completes
// (R21) Change counter wraps modulo 256
module fb_frame_adapter #(
  parameter int MAX_LEN = fb_frame_pkg::MAX_LEN,
  parameter int AW = 9,
  parameter int TMO_W = 24,
  parameter int IDLE_TIMEOUT_CYCLES = fb_frame_pkg::IDLE_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // AXI4-Lite register slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Fieldbus process data
  input wire logic FB_LINK_UP,
  input wire logic FB_WR_EN,
  input wire logic [AW-1:0] FB_WR_ADDR,
  input wire logic [7:0] FB_WR_DATA,
  input wire logic FB_OUT_UPDATE,
  input wire logic [AW-1:0] FB_RD_ADDR,
  output logic [7:0] FB_RD_DATA,
  output logic FB_IN_UPDATE,
  // Serial character stream
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic RX_OVERFLOW
);

  if (MAX_LEN < 1 || MAX_LEN > 2 ** AW - 1 || TMO_W < 2 || TMO_W > 32 ||
      IDLE_TIMEOUT_CYCLES < 1 ||
      (TMO_W < 31 && IDLE_TIMEOUT_CYCLES >= 2 ** TMO_W)) begin : g_chk
    $error("fb_frame_adapter: unsupported parameter values");
  end

  logic [7:0] out_mem [MAX_LEN];
  logic [7:0] in_mem [MAX_LEN];
  logic [7:0] rx_buf [MAX_LEN];

  fb_frame_pkg::cfg_t cfg_q;
  logic [AW-1:0] in_len_q, out_len_q;
  logic [TMO_W-1:0] tmo_q;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [AW-1:0] clamp_len(input logic [15:0] v);
    if (v > 16'(MAX_LEN)) return AW'(MAX_LEN);
    return v[AW-1:0];
  endfunction

  // AXI4-Lite write channel, one write outstanding
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic do_write, wr_known, ovf_clr, ctrl_wr;
  logic [31:0] ctrl_w, blk_w, tmo_w;

  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_known = awaddr_q[1:0] == 2'b00 &&
                    awaddr_q <= fb_frame_pkg::REG_COUNTS;
  assign ovf_clr = do_write && awaddr_q == fb_frame_pkg::REG_STATUS &&
                   wstrb_q[0] && wdata_q[fb_frame_pkg::STAT_OVF];
  assign ctrl_wr = do_write && awaddr_q == fb_frame_pkg::REG_CTRL;
  assign ctrl_w = wmerge({8'h00, cfg_q}, wdata_q, wstrb_q) & 32'h00ff_ff7f;
  assign blk_w = wmerge({16'(out_len_q), 16'(in_len_q)}, wdata_q, wstrb_q);
  assign tmo_w = wmerge(32'(tmo_q), wdata_q, wstrb_q);

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= fb_frame_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && awready_q) begin
        awaddr_q <= S_AXI_AWADDR;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (S_AXI_WVALID && wready_q) begin
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? fb_frame_pkg::RESP_OKAY
                            : fb_frame_pkg::RESP_SLVERR;
      end
      if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Configuration registers steer the framer
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cfg_q <= fb_frame_pkg::cfg_t'(fb_frame_pkg::CTRL_RST[23:0]);
      in_len_q <= AW'(fb_frame_pkg::BLOCK_LEN_RST);
      out_len_q <= AW'(fb_frame_pkg::BLOCK_LEN_RST);
      tmo_q <= TMO_W'(IDLE_TIMEOUT_CYCLES);
    end else if (do_write) begin
      case (awaddr_q)
        fb_frame_pkg::REG_CTRL: begin
          cfg_q <= fb_frame_pkg::cfg_t'(ctrl_w[23:0]);
        end
        fb_frame_pkg::REG_BLOCK: begin
          in_len_q <= clamp_len(blk_w[15:0]); // [R19]
          out_len_q <= clamp_len(blk_w[31:16]); // [R19]
        end
        fb_frame_pkg::REG_TIMEOUT: begin
          tmo_q <= tmo_w[TMO_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Shared framing terms
  logic [1:0] hdr;
  logic len_on;
  logic [AW-1:0] rx_cap, tx_cap;

  assign hdr = fb_frame_pkg::hdr_len(cfg_q);
  assign len_on = cfg_q.len_en &&
                  cfg_q.end_mode != fb_frame_pkg::END_TIMEOUT; // [R10]
  assign rx_cap = in_len_q > AW'(hdr) ? in_len_q - AW'(hdr) : '0;
  assign tx_cap = out_len_q > AW'(hdr) ? out_len_q - AW'(hdr) : '0;

  // Serial receive
  fb_frame_pkg::rx_state_t rx_state_q;
  logic [AW-1:0] cnt_q, copy_idx_q, last_cnt_q, stored, data_idx;
  logic [7:0] exp_q, trig_cnt_q, copy_byte;
  logic [TMO_W-1:0] idle_q;
  logic [15:0] rx_frames_q;
  logic ovf_q, in_upd_q, rx_byte, end_hit, data_byte, idle_hit, ovf_set;

  assign rx_byte = RX_VALID && FB_LINK_UP; // [R20]
  assign end_hit = !len_on && cfg_q.end_mode == fb_frame_pkg::END_CHAR &&
                   RX_DATA == cfg_q.end_char; // [R8]
  assign data_byte = rx_state_q == fb_frame_pkg::R_DATA && rx_byte &&
                     !end_hit;
  assign idle_hit = idle_q == tmo_q;
  assign ovf_set = data_byte && cnt_q >= rx_cap; // [R15]
  assign stored = cnt_q > rx_cap ? rx_cap : cnt_q;
  assign data_idx = copy_idx_q - AW'(hdr);

  always_comb begin
    if (cfg_q.trig_en && copy_idx_q == '0) begin
      copy_byte = trig_cnt_q + 8'h01; // [R18] [R21]
    end else if (cfg_q.cnt_en && copy_idx_q == AW'(cfg_q.trig_en)) begin
      copy_byte = stored > AW'(8'hff) ? 8'hff : stored[7:0]; // [R17]
    end else if (data_idx < stored) begin
      copy_byte = rx_buf[data_idx];
    end else begin
      copy_byte = 8'h00; // [R16]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rx_state_q <= fb_frame_pkg::R_IDLE;
      cnt_q <= '0;
      exp_q <= 8'h00;
      idle_q <= '0;
      copy_idx_q <= '0;
      trig_cnt_q <= 8'h00;
      in_upd_q <= 1'b0;
      rx_frames_q <= 16'h0000;
      last_cnt_q <= '0;
    end else begin
      in_upd_q <= 1'b0;
      case (rx_state_q)
        fb_frame_pkg::R_IDLE: begin
          cnt_q <= '0;
          idle_q <= '0;
          copy_idx_q <= '0;
          if (!cfg_q.start_en ||
              (rx_byte && RX_DATA == cfg_q.start_char)) begin // [R1]
            rx_state_q <= len_on ? fb_frame_pkg::R_LEN
                                 : fb_frame_pkg::R_DATA;
          end
        end
        fb_frame_pkg::R_LEN: begin
          if (rx_byte) begin
            exp_q <= RX_DATA; // [R3]
            rx_state_q <= RX_DATA == 8'h00 ? fb_frame_pkg::R_COPY
                                           : fb_frame_pkg::R_DATA;
          end
        end
        fb_frame_pkg::R_DATA: begin
          if (rx_byte) begin
            idle_q <= '0;
            if (end_hit) begin
              rx_state_q <= fb_frame_pkg::R_COPY; // [R5] [R8]
            end else begin
              if (cnt_q != '1) cnt_q <= cnt_q + 1'b1;
              if (len_on && cnt_q + 1'b1 == AW'(exp_q)) begin
                rx_state_q <= fb_frame_pkg::R_COPY; // [R3]
              end else if (!len_on &&
                           cfg_q.end_mode == fb_frame_pkg::END_NONE &&
                           cnt_q + 1'b1 >= rx_cap) begin
                rx_state_q <= fb_frame_pkg::R_COPY; // [R6]
              end
            end
          end else if (!idle_hit) begin
            idle_q <= idle_q + 1'b1;
          end else if (cfg_q.end_mode == fb_frame_pkg::END_TIMEOUT &&
                       cnt_q != '0) begin
            rx_state_q <= fb_frame_pkg::R_COPY; // [R9]
          end else if (len_on && cfg_q.len_tmo) begin
            rx_state_q <= fb_frame_pkg::R_IDLE; // [R7]
          end
        end
        fb_frame_pkg::R_COPY: begin
          copy_idx_q <= copy_idx_q + 1'b1;
          if (in_len_q == '0 || copy_idx_q == in_len_q - 1'b1) begin
            rx_state_q <= fb_frame_pkg::R_IDLE;
            if (cfg_q.trig_en) trig_cnt_q <= trig_cnt_q + 8'h01; // [R18]
            in_upd_q <= 1'b1;
            rx_frames_q <= rx_frames_q + 16'h0001;
            last_cnt_q <= stored;
          end
        end
        default: rx_state_q <= fb_frame_pkg::R_IDLE;
      endcase
      // New frame format: drop a frame still being received under the old one
      if (ctrl_wr && rx_state_q != fb_frame_pkg::R_COPY) begin
        rx_state_q <= fb_frame_pkg::R_IDLE; // [R1]
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (data_byte && cnt_q < rx_cap) rx_buf[cnt_q] <= RX_DATA; // [R15]
  end

  always_ff @(posedge CLOCK) begin
    if (rx_state_q == fb_frame_pkg::R_COPY && copy_idx_q < in_len_q) begin
      in_mem[copy_idx_q] <= copy_byte; // [R16]
    end
  end

  // Overflow flag, a new overflow wins over a clear
  always_ff @(posedge CLOCK) begin
    if (SRST) ovf_q <= 1'b0;
    else ovf_q <= (ovf_q && !ovf_clr) || ovf_set; // [R15]
  end

  // Fieldbus side of the data areas
  logic [7:0] fb_rd_q, trig_val_q, prefix_q;

  always_ff @(posedge CLOCK) begin
    if (FB_WR_EN && FB_WR_ADDR < AW'(MAX_LEN)) begin
      out_mem[FB_WR_ADDR] <= FB_WR_DATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      fb_rd_q <= 8'h00;
      trig_val_q <= 8'h00;
      prefix_q <= 8'h00;
    end else begin
      fb_rd_q <= FB_RD_ADDR < AW'(MAX_LEN) ? in_mem[FB_RD_ADDR] : 8'h00;
      if (FB_WR_EN && FB_WR_ADDR == '0) trig_val_q <= FB_WR_DATA;
      if (FB_WR_EN && FB_WR_ADDR == AW'(cfg_q.trig_en)) begin
        prefix_q <= FB_WR_DATA;
      end
    end
  end

  // Serial transmit
  fb_frame_pkg::tx_state_t tx_state_q;
  logic [AW-1:0] tx_n_q, tx_idx_q, tx_sent_q, tx_n;
  logic [7:0] tx_data_q, trig_sent_q;
  logic [15:0] tx_frames_q;
  logic tx_valid_q, upd_pend_q, tx_go, tx_fire;

  always_comb begin
    tx_n = tx_cap;
    if (cfg_q.cnt_en && AW'(prefix_q) < tx_cap) tx_n = AW'(prefix_q); // [R14]
    if (len_on && tx_n > AW'(8'hff)) tx_n = AW'(8'hff);
  end

  assign tx_go = FB_LINK_UP && (cfg_q.trig_en ? trig_val_q != trig_sent_q
                                              : upd_pend_q); // [R13] [R20]
  assign tx_fire = tx_valid_q && TX_READY;

  always_ff @(posedge CLOCK) begin
    if (SRST) upd_pend_q <= 1'b0;
    else if (FB_OUT_UPDATE) upd_pend_q <= 1'b1;
    else if (tx_state_q == fb_frame_pkg::T_IDLE && tx_go) upd_pend_q <= 1'b0;
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      tx_state_q <= fb_frame_pkg::T_IDLE;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_n_q <= '0;
      tx_idx_q <= '0;
      tx_sent_q <= '0;
      trig_sent_q <= 8'h00;
      tx_frames_q <= 16'h0000;
    end else begin
      case (tx_state_q)
        fb_frame_pkg::T_IDLE: begin
          if (tx_go) begin
            trig_sent_q <= trig_val_q; // [R13]
            tx_n_q <= tx_n;
            tx_idx_q <= AW'(hdr);
            tx_sent_q <= '0;
            if (cfg_q.start_en) tx_state_q <= fb_frame_pkg::T_START;
            else if (len_on) tx_state_q <= fb_frame_pkg::T_LEN;
            else if (tx_n != '0) tx_state_q <= fb_frame_pkg::T_DATA;
            else tx_state_q <= fb_frame_pkg::T_END;
          end
        end
        fb_frame_pkg::T_START: begin
          if (!tx_valid_q) begin
            tx_data_q <= cfg_q.start_char; // [R2]
            tx_valid_q <= 1'b1;
          end else if (tx_fire) begin
            tx_valid_q <= 1'b0;
            if (len_on) tx_state_q <= fb_frame_pkg::T_LEN;
            else if (tx_n_q != '0) tx_state_q <= fb_frame_pkg::T_DATA;
            else tx_state_q <= fb_frame_pkg::T_END;
          end
        end
        fb_frame_pkg::T_LEN: begin
          if (!tx_valid_q) begin
            tx_data_q <= tx_n_q[7:0]; // [R4]
            tx_valid_q <= 1'b1;
          end else if (tx_fire) begin
            tx_valid_q <= 1'b0;
            tx_state_q <= tx_n_q != '0 ? fb_frame_pkg::T_DATA
                                       : fb_frame_pkg::T_END;
          end
        end
        fb_frame_pkg::T_DATA: begin
          if (!tx_valid_q) begin
            tx_data_q <= out_mem[tx_idx_q]; // [R12]
            tx_valid_q <= 1'b1;
          end else if (tx_fire) begin
            tx_valid_q <= 1'b0;
            tx_idx_q <= tx_idx_q + 1'b1;
            tx_sent_q <= tx_sent_q + 1'b1;
            if (tx_sent_q + 1'b1 == tx_n_q) begin
              tx_state_q <= fb_frame_pkg::T_END;
            end
          end
        end
        fb_frame_pkg::T_END: begin
          if (cfg_q.end_mode != fb_frame_pkg::END_CHAR) begin
            tx_state_q <= fb_frame_pkg::T_IDLE; // [R12]
            tx_frames_q <= tx_frames_q + 16'h0001;
          end else if (!tx_valid_q) begin
            tx_data_q <= cfg_q.end_char; // [R11]
            tx_valid_q <= 1'b1;
          end else if (tx_fire) begin
            tx_valid_q <= 1'b0;
            tx_state_q <= fb_frame_pkg::T_IDLE;
            tx_frames_q <= tx_frames_q + 16'h0001;
          end
        end
        default: tx_state_q <= fb_frame_pkg::T_IDLE;
      endcase
    end
  end

  // AXI4-Lite read channel
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q, rd_c;
  logic [1:0] rresp_q, rresp_c;

  always_comb begin
    rd_c = 32'h0000_0000;
    rresp_c = fb_frame_pkg::RESP_OKAY;
    case (S_AXI_ARADDR)
      fb_frame_pkg::REG_CTRL: rd_c = {8'h00, cfg_q};
      fb_frame_pkg::REG_BLOCK: begin
        rd_c[fb_frame_pkg::BLOCK_IN_LSB +: AW] = in_len_q;
        rd_c[fb_frame_pkg::BLOCK_OUT_LSB +: AW] = out_len_q;
      end
      fb_frame_pkg::REG_TIMEOUT: rd_c[TMO_W-1:0] = tmo_q;
      fb_frame_pkg::REG_STATUS: begin
        rd_c[fb_frame_pkg::STAT_OVF] = ovf_q;
        rd_c[fb_frame_pkg::STAT_LINK] = FB_LINK_UP;
        rd_c[fb_frame_pkg::STAT_RX_BUSY] = rx_state_q != fb_frame_pkg::R_IDLE;
        rd_c[fb_frame_pkg::STAT_TX_BUSY] = tx_state_q != fb_frame_pkg::T_IDLE;
        rd_c[fb_frame_pkg::STAT_TRIG_LSB +: 8] = trig_cnt_q;
        rd_c[fb_frame_pkg::STAT_LAST_LSB +: AW] = last_cnt_q;
      end
      fb_frame_pkg::REG_COUNTS: begin
        rd_c = {tx_frames_q, rx_frames_q};
      end
      default: rresp_c = fb_frame_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= fb_frame_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_c;
      rresp_q <= rresp_c;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign FB_RD_DATA = fb_rd_q;
  assign FB_IN_UPDATE = in_upd_q;
  assign TX_DATA = tx_data_q;
  assign TX_VALID = tx_valid_q;
  assign RX_OVERFLOW = ovf_q;

endmodule

/* test/fb_frame_adapter_sva.sv */
`timescale 1ns/1ps
module fb_frame_adapter_sva (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // Register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Fieldbus and serial
  input wire logic FB_IN_UPDATE,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic RX_OVERFLOW
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (SRST);
  sequence s_wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_tx_take;
    TX_VALID && TX_READY;
  endsequence
  a_b_answer: assert property (s_wr_take |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_ready_back: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
    S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write channels not ready again");
  a_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |->
    ##[1:2] S_AXI_RVALID)
    else $error("read response missing");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read response dropped");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA))
    else $error("serial byte changed while waiting");
  a_tx_bubble: assert property (s_tx_take |=> !TX_VALID)
    else $error("no gap after serial byte");
  a_upd_pulse: assert property (FB_IN_UPDATE |=> !FB_IN_UPDATE)
    else $error("update pulse too long");
  a_ovf_sticky: assert property (RX_OVERFLOW |=>
    RX_OVERFLOW || S_AXI_BVALID)
    else $error("overflow flag lost");
endmodule

/* test/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer (
  // Serial stream
  input wire logic CLOCK,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID
);
  logic [7:0] got[$];
  initial begin
    TX_READY = 1'b0;
    RX_DATA = 8'h00;
    RX_VALID = 1'b0;
  end
  // Random stalls on the receive side of the far device
  always @(posedge CLOCK) begin
    if (TX_VALID === 1'b1 && TX_READY) got.push_back(TX_DATA);
    TX_READY <= ($urandom % 3) != 0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge CLOCK);
    RX_DATA <= b;
    RX_VALID <= 1'b1;
    @(posedge CLOCK);
    RX_VALID <= 1'b0;
    RX_DATA <= ~b;
  endtask
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  logic clock = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, link = 0, wr_en = 0, out_upd = 0;
  logic awready, wready, bvalid, arready, rvalid, upd, txv, txr, rxv, ovf;
  logic [7:0] awaddr = 0, araddr = 0, wr_data = 0, fd, rd_data, txd, rxd;
  logic [8:0] wr_addr = 0, rd_addr = 0;
  logic [31:0] wdata = 0, rdata, r;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] sq[$], eq[$];
  int errors = 0, samples_checked = 0;
  bit seen;
  initial forever #2.5 clock = ~clock;
  fb_frame_adapter #(.IDLE_TIMEOUT_CYCLES(20)) i_fb_frame_adapter (
    .CLOCK(clock), .SRST(srst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .FB_LINK_UP(link), .FB_WR_EN(wr_en),
    .FB_WR_ADDR(wr_addr), .FB_WR_DATA(wr_data), .FB_OUT_UPDATE(out_upd),
    .FB_RD_ADDR(rd_addr), .FB_RD_DATA(rd_data), .FB_IN_UPDATE(upd),
    .RX_DATA(rxd), .RX_VALID(rxv), .TX_DATA(txd), .TX_VALID(txv),
    .TX_READY(txr), .RX_OVERFLOW(ovf));
  serial_peer i_serial_peer (.CLOCK(clock), .TX_DATA(txd), .TX_VALID(txv),
    .TX_READY(txr), .RX_DATA(rxd), .RX_VALID(rxv));
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit b;
    n = 0;
    b = 0;
    @(posedge clock);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
    end else begin
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
    end
    while (!b) begin
      @(posedge clock);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (arvalid && arready) arvalid <= 0;
      if (bvalid === 1'b1 && bready) begin
        b = 1;
        rs = bresp;
        bready <= 0;
      end
      if (rvalid === 1'b1 && rready) begin
        b = 1;
        rs = rresp;
        r = rdata;
        rready <= 0;
      end
      if (n > 200) begin
        errors++;
        final_report();
      end
    end
  endtask
  task automatic fbw(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_addr <= a;
    wr_data <= d;
    wr_en <= 1;
    @(posedge clock);
    wr_en <= 0;
  endtask
  function automatic logic [7:0] rb();
    return 8'h20 + 8'($urandom % 64);
  endfunction
  task automatic mk(input int n);
    logic [7:0] b;
    repeat (n) begin
      b = rb();
      sq.push_back(b);
      eq.push_back(b);
    end
  endtask
  // Send sq, check the update pulse against exp, then if exp compare the first 8 master-bound bytes with eq
  task automatic rx_frame(input bit exp);
    foreach (sq[i]) i_serial_peer.send(sq[i]);
    seen = 0;
    for (int i = 0; i < 100 && !seen; i++) begin
      @(posedge clock);
      if (upd === 1'b1) seen = 1;
    end
    `CHK(seen, exp)
    for (int i = 0; i < 8 && exp; i++) begin
      @(posedge clock);
      rd_addr <= 9'(i);
      @(posedge clock);
      @(posedge clock);
      fd = rd_data;
      `CHK(fd, i < eq.size() ? eq[i] : 8'h00)
    end
  endtask
  initial begin
    void'($urandom(32'h9a9d));
    repeat (20) @(posedge clock);
    srst <= 0;
    @(posedge clock);
    `CHK(ovf, 1'b0)
    axi(0, fb_frame_pkg::REG_CTRL, 0);
    `CHK(r, 32'h0000_0000)
    axi(0, fb_frame_pkg::REG_BLOCK, 0);
    `CHK(r, 32'h01f4_01f4)
    axi(0, 8'h40, 0);
    `CHK(rs, fb_frame_pkg::RESP_SLVERR)
    axi(1, 8'h02, 32'h1);
    `CHK(rs, fb_frame_pkg::RESP_SLVERR)
    axi(1, fb_frame_pkg::REG_BLOCK, 32'h0008_0008);
    axi(0, fb_frame_pkg::REG_BLOCK, 0);
    `CHK(r, 32'h0008_0008)
    $display("test registers done");
    axi(1, fb_frame_pkg::REG_CTRL, 32'h000d_a569);
    sq = {8'h11, 8'h0d, 8'ha5};
    eq = {8'h01, 8'h03};
    mk(3);
    sq.push_back(8'h0d);
    rx_frame(0);
    link <= 1;
    rx_frame(1);
    sq = {8'ha5};
    eq = {8'h02, 8'h06};
    mk(6);
    sq.push_back(rb());
    sq.push_back(rb());
    sq.push_back(8'h0d);
    rx_frame(1);
    `CHK(ovf, 1'b1)
    axi(1, fb_frame_pkg::REG_STATUS, 32'h1);
    `CHK(ovf, 1'b0)
    $display("test marker frames done");
    axi(1, fb_frame_pkg::REG_CTRL, 32'h2);
    sq = {8'h04};
    eq = {};
    mk(4);
    rx_frame(1);
    axi(1, fb_frame_pkg::REG_CTRL, 32'h6);
    sq = {8'h05, rb(), rb()};
    rx_frame(0);
    sq = {8'h02};
    eq = {};
    mk(2);
    rx_frame(1);
    axi(1, fb_frame_pkg::REG_CTRL, 32'h12);
    sq = {};
    eq = {};
    mk(3);
    rx_frame(1);
    axi(1, fb_frame_pkg::REG_CTRL, 32'h0);
    sq = {};
    eq = {};
    mk(8);
    rx_frame(1);
    $display("test end criteria done");
    axi(1, fb_frame_pkg::REG_CTRL, 32'h000d_a56b);
    i_serial_peer.got = {};
    eq = {8'ha5, 8'h03};
    fbw(1, 8'h03);
    for (int i = 0; i < 3; i++) begin
      fd = rb();
      eq.push_back(fd);
      fbw(9'(2 + i), fd);
    end
    fbw(5, 8'h77);
    eq.push_back(8'h0d);
    fbw(0, 8'h5a);
    for (int i = 0; i < 300 && i_serial_peer.got.size() < 6; i++)
      @(posedge clock);
    repeat (60) @(posedge clock);
    `CHK(i_serial_peer.got.size(), 6)
    foreach (eq[i]) `CHK(i_serial_peer.got[i], eq[i])
    axi(1, fb_frame_pkg::REG_CTRL, 32'h0);
    axi(1, fb_frame_pkg::REG_BLOCK, 32'h0002_0008);
    i_serial_peer.got = {};
    out_upd <= 1;
    @(posedge clock);
    out_upd <= 0;
    for (int i = 0; i < 300 && i_serial_peer.got.size() < 2; i++)
      @(posedge clock);
    repeat (30) @(posedge clock);
    `CHK(i_serial_peer.got.size(), 2)
    `CHK(i_serial_peer.got[0], 8'h5a)
    `CHK(i_serial_peer.got[1], 8'h03)
    $display("test transmit done");
    axi(1, fb_frame_pkg::REG_CTRL, 32'h000d_0028);
    repeat (253) begin
      i_serial_peer.send(8'h0d);
      repeat (12) @(posedge clock);
    end
    sq = {8'h42, 8'h0d};
    eq = {8'h00, 8'h42};
    rx_frame(1);
    $display("test counter wrap done");
    final_report();
  end
endmodule
bind fb_frame_adapter fb_frame_adapter_sva i_fb_frame_adapter_sva (
  .CLOCK(CLOCK), .SRST(SRST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .FB_IN_UPDATE(FB_IN_UPDATE), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
  .TX_READY(TX_READY), .RX_OVERFLOW(RX_OVERFLOW));
